// >>> test_wlan_mac_channel_access_timing.sv
// self-checking bench for the channel-access and timing core
// assumes wct_pkg and wct_channel_access compiled first
`timescale 1ns/1ps
`default_nettype none
module test_wlan_mac_channel_access_timing;
  import wct_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observation
  // ---------------------------------------------------------------
  logic mclk = 0, reset = 1, phyBusy = 0, slowTick = 0, grantPol = 0;
  logic hostReq = 0, seqReq = 0, freqSet = FREQ_FN_RST;
  logic wantAir = 0, highPrio = 0, prioDir, rfActive, restricted, txOn;
  wct_cmd_t cmd = '0;
  wct_pol_t pol = WCT_POL_LOW;
  logic [3:0] qRdy = 4'h0, coexEn = 4'h0, gOut = 4'h0, gOe = 4'h0;
  logic [2:0] fnSet = COEX_FN_RST;
  logic [TSF_W-1:0] tbtt = '1, offs = '1, tsfNow;
  logic [3:0] pinOut, pinOe, padLvl, txStart;
  logic peerAct, rifsTrig, sifsTrig, tbttTrig, offsTrig, navBusy;
  logic macClkEn, wakeEv;
  logic [1:0] phyGrant;
  logic [7:0] ev;
  int err_count = 0, compares = 0;
  always #20 mclk = ~mclk;
  // undriven grant pad shows the inverse of pinOut[2]
  assign padLvl = (pinOe & pinOut) |
    (~pinOe & {restricted, ~pinOut[2], rfActive, prioDir});
  assign ev = {wakeEv, offsTrig, tbttTrig, ~navBusy, sifsTrig, rifsTrig,
    |txStart, 1'b0};
  wct_channel_access dut_u (.mclk(mclk), .reset(reset), .seqCmd(cmd),
    .queueReady(qRdy), .arbPolicy(pol), .phyBusy(phyBusy),
    .tbttTarget(tbtt), .offsetTarget(offs), .slowTick(slowTick),
    .pinIn(padLvl), .coexPinFnSet(fnSet), .freqPinFnSet(freqSet),
    .coexEnable(coexEn), .gpioOut(gOut), .gpioOe(gOe),
    .grantPolicy(grantPol), .hostPhyReq(hostReq), .seqPhyReq(seqReq),
    .pinOut(pinOut), .pinOe(pinOe), .gpioIn(), .peerActive(peerAct),
    .rifsTrig(rifsTrig), .sifsTrig(sifsTrig), .txStart(txStart),
    .tsfNow(tsfNow), .tbttTrig(tbttTrig), .offsetTrig(offsTrig),
    .navBusy(navBusy), .macClkEn(macClkEn), .wakeEvent(wakeEv),
    .phyCtlGrant(phyGrant));
  wct_peer_radio peer_u (.mclk(mclk), .wantAir(wantAir),
    .highPrio(highPrio), .grantPad(padLvl[2]), .prioDir(prioDir),
    .rfActive(rfActive), .restricted(restricted), .txOn(txOn));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [63:0] exp,
                     input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  // bounded wait for an event bit, sampled just after each edge
  task automatic waitEv(input int b, input int lim, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
      if (n > lim) begin
        err_count++;
        $display("MISMATCH event %0d expected 1 seen 0", b);
        finish_test();
      end
    end while (ev[b] !== 1'b1);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int n, r, s, tally, expQ[$];
    logic [63:0] v;
    void'($urandom(30925));
    tick(16);
    reset <= 1'b0;
    gOe <= 4'hf;
    gOut <= 4'ha;
    tick(3);
    #1;
    chk("oe default", 4'h8, pinOe & 4'hb);
    chk("gpio3 out", 1'b1, pinOut[3]);
    wantAir <= 1'b1;
    tick(1);
    fnSet <= 3'h0;
    freqSet <= 1'b1;
    tick(3);
    #1;
    chk("oe moved", 4'h7, pinOe);
    chk("peer off", 1'b0, peerAct);
    tick(1);
    fnSet <= COEX_FN_RST;
    coexEn <= 4'hf;
    grantPol <= 1'b1;
    highPrio <= 1'b1;
    tick(4);
    #1;
    chk("peer on", 1'b1, peerAct);
    chk("grant", 1'b1, pinOut[2] & pinOe[2]);
    chk("peer air", 1'b1, txOn);
    tick(1);
    wantAir <= 1'b0;
    $display("test coex done");
    // spacing: count edges from medium idle to each trigger
    phyBusy <= 1'b1;
    tick(5);
    phyBusy <= 1'b0;
    r = 0;
    s = 0;
    for (n = 1; n <= 300; n++) begin
      @(posedge mclk);
      #1;
      if (rifsTrig === 1'b1 && r == 0) r = n;
      if (sifsTrig === 1'b1 && s == 0) s = n;
    end
    chk("rifs gap", 1, r >= RIFS_US*US_CYC && r <= RIFS_US*US_CYC+1);
    chk("sifs gap", 1, s >= SIFS_US*US_CYC && s <= SIFS_US*US_CYC+1);
    $display("test spacing done");
    // nav: larger load taken, smaller one refused, busy until zero
    tick(1);
    v = 64'h14 + 64'($urandom % 8);
    cmd.navLoad <= 1'b1;
    cmd.navValue <= v[NAV_W-1:0];
    tick(1);
    cmd.navValue <= 16'h2;
    tick(1);
    cmd.navLoad <= 1'b0;
    waitEv(4, 1000, n);
    chk("nav span", 1, n + 2 >= (v-1)*US_CYC && n <= v*US_CYC + 2);
    $display("test nav done");
    // tsf: adopt a random stamp, then offset and beacon triggers
    tick(1);
    v = {1'b0, 31'($urandom), 32'($urandom)};
    cmd.tsfLoad <= 1'b1;
    cmd.tsfValue <= v;
    offs <= v + 64'h2;
    tbtt <= v + 64'h3;
    tick(1);
    cmd.tsfLoad <= 1'b0;
    #1;
    chk("tsf adopt", 1, tsfNow === v || tsfNow === v + 64'h1);
    waitEv(6, 4*US_CYC, n);
    chk("offset", 1, tsfNow >= v + 64'h2 && tsfNow <= v + 64'h3);
    waitEv(5, 2*US_CYC, n);
    chk("tbtt", 1, tsfNow >= v + 64'h3 && tsfNow <= v + 64'h4);
    $display("test tsf done");
    // back-off per policy: pause in busy slots, then winner order
    for (int p = 0; p < 3; p++) begin
      tick(1);
      pol <= wct_pol_t'(p);
      expQ = (p == 1) ? '{4'h4, 4'h1} : '{4'h1, 4'h4};
      cmd.boLoad <= 4'h5;
      cmd.boValue <= 10'h2;
      qRdy <= 4'h5;
      phyBusy <= 1'b1;
      tick(1);
      cmd.boLoad <= 4'h0;
      tally = 0;
      repeat (3*SLOT_US*US_CYC) begin
        @(posedge mclk);
        #1;
        if (txStart !== 4'h0) tally++;
      end
      chk("busy hold", 0, tally);
      tick(1);
      phyBusy <= 1'b0;
      foreach (expQ[i]) begin
        waitEv(1, 1500, n);
        chk("winner", expQ[i], txStart);
      end
    end
    $display("test backoff done");
    // sleep walk: gate drops, two slow ticks, wake pulse
    tick(1);
    qRdy <= 4'h0;
    cmd.sleepStart <= 1'b1;
    cmd.sleepCount <= 32'h2;
    tick(1);
    cmd.sleepStart <= 1'b0;
    tick(1);
    #1;
    chk("clk gated", 1'b0, macClkEn);
    repeat (2) begin
      tick(1);
      slowTick <= 1'b1;
      tick(1);
      slowTick <= 1'b0;
    end
    #1;
    chk("wake pulse", 1'b1, wakeEv);
    tick(1);
    #1;
    chk("clk back", 1'b1, macClkEn);
    $display("test sleep done");
    // phy control from either requester
    tick(1);
    hostReq <= 1'b1;
    tick(3);
    #1;
    chk("phy host", 2'h1, phyGrant);
    tick(1);
    hostReq <= 1'b0;
    seqReq <= 1'b1;
    tick(3);
    #1;
    chk("phy seq", 2'h2, phyGrant);
    $display("test phy control done");
    finish_test();
  end
endmodule // test_wlan_mac_channel_access_timing
`default_nettype wire

// >>> wct_channel_access.sv
// channel-access and timing core: spacing timers, back-off, nav, tsf,
// sleep timer and coexistence handshake with pin muxing
// assumes all inputs synchronous to mclk; slow clock given as an enable
//
// Summary of operation
// - three coex pins default coex, software reassignable
// - fourth pin defaults gpio, switchable to restricted
// - each coex signal off until individually enabled
// - grant output gates peer transmission
// - spacing timers start when medium goes idle
// - spacing timers give exact transmit start triggers
// - one back-off engine per category, per slot
// - counter at zero notifies transmit engine
// - simultaneous zeros resolved by sequencer policy
// - sequencer picks queue, transmit on spacing trigger
// - sleep timer on slow clock while mac stopped
// - expiry restarts mac clock and function
// - sequencer advances tsf by sleep time
// - tsf adopts received timestamp on command
// - tbtt kept, offset triggers raised
// - nav loaded from duration, counts down
// - nonzero nav is virtual carrier sense
// - phy control reachable by host or sequencer
`timescale 1ns/1ps
`default_nettype none
module wct_channel_access
  import wct_pkg::*;
#(
  parameter int NUM_CAT = NUM_AC
) (
  input wire logic mclk,
  input wire logic reset,
  input wire wct_cmd_t seqCmd,
  input wire logic [NUM_CAT-1:0] queueReady,
  input wire wct_pol_t arbPolicy,
  input wire logic phyBusy,
  input wire logic [TSF_W-1:0] tbttTarget,
  input wire logic [TSF_W-1:0] offsetTarget,
  input wire logic slowTick,
  input wire logic [3:0] pinIn,
  input wire logic [2:0] coexPinFnSet,
  input wire logic freqPinFnSet,
  input wire logic [3:0] coexEnable,
  input wire logic [3:0] gpioOut,
  input wire logic [3:0] gpioOe,
  input wire logic grantPolicy,
  input wire logic hostPhyReq,
  input wire logic seqPhyReq,
  output logic [3:0] pinOut,
  output logic [3:0] pinOe,
  output logic [3:0] gpioIn,
  output logic peerActive,
  output logic rifsTrig,
  output logic sifsTrig,
  output logic [NUM_CAT-1:0] txStart,
  output logic [TSF_W-1:0] tsfNow,
  output logic tbttTrig,
  output logic offsetTrig,
  output logic navBusy,
  output logic macClkEn,
  output logic wakeEvent,
  output logic [1:0] phyCtlGrant
);
  // -------------------------------------------------------------
  // pin muxing: pins 0..2 are priority, activity, grant; pin 3 freq
  // -------------------------------------------------------------
  logic [2:0] fn_reg, fn_next;
  logic freqFn_reg, freqFn_next;
  logic [3:0] en_reg, en_next;
  logic grant_reg, grant_next;
  logic peerPrio, peerAct, peerFreq;
  // function select follows software; reset puts pins 0..2 in coex role, pin 3 gpio
  always_comb begin
    fn_next = coexPinFnSet;
    freqFn_next = freqPinFnSet;
    en_next = coexEnable;
  end
  // inputs only act once enabled and muxed to coex role
  always_comb begin
    peerPrio = fn_reg[0] & en_reg[0] & pinIn[0];
    peerAct = fn_reg[1] & en_reg[1] & pinIn[1];
    peerFreq = freqFn_reg & en_reg[3] & pinIn[3];
    gpioIn = pinIn & ~{freqFn_reg, fn_reg};
    pinOut = gpioOut;
    pinOe = gpioOe;
    pinOe[0] = fn_reg[0] ? 1'b0 : gpioOe[0];
    pinOe[1] = fn_reg[1] ? 1'b0 : gpioOe[1];
    pinOe[3] = freqFn_reg ? 1'b0 : gpioOe[3];
    if (fn_reg[2]) begin
      pinOut[2] = grant_reg;
      pinOe[2] = 1'b1;
    end
    peerActive = peerAct;
  end
  // grant: refuse peer while phy busy or peer freq pin set, unless grantPolicy set and peer high prio
  always_comb begin
    grant_next = 1'b0;
    if (en_reg[2]) begin
      grant_next = (!phyBusy && !peerFreq) ||
        (grantPolicy && peerPrio);
    end
  end
  // -------------------------------------------------------------
  // spacing timers
  // -------------------------------------------------------------
  localparam int RIFS_CYC = RIFS_US * US_CYC;
  localparam int SIFS_CYC = SIFS_US * US_CYC;
  localparam int SLOT_CYC = SLOT_US * US_CYC;
  logic [15:0] ifs_reg, ifs_next;
  logic [15:0] slot_reg, slot_next;
  logic busyPrev_reg, slotIdle_reg, slotIdle_next;
  logic medBusy, slotEnd;
  assign medBusy = phyBusy | navBusy | peerAct;
  // counter restarts on the falling edge of medium activity
  always_comb begin
    ifs_next = ifs_reg;
    if (medBusy) begin
      ifs_next = 16'h0;
    end else if (busyPrev_reg) begin
      ifs_next = 16'h1;
    end else if (ifs_reg != 16'hffff) begin
      ifs_next = ifs_reg + 16'h1;
    end
    rifsTrig = !medBusy && ifs_reg == 16'(RIFS_CYC);
    sifsTrig = !medBusy && ifs_reg == 16'(SIFS_CYC);
  end
  // slots start after sifs; a slot counts idle only if idle throughout
  always_comb begin
    slot_next = slot_reg;
    slotIdle_next = slotIdle_reg & ~medBusy;
    slotEnd = 1'b0;
    if (medBusy || ifs_reg < 16'(SIFS_CYC)) begin
      slot_next = 16'h0;
      slotIdle_next = 1'b1;
    end else if (slot_reg == 16'(SLOT_CYC - 1)) begin
      slot_next = 16'h0;
      slotEnd = 1'b1;
      slotIdle_next = 1'b1;
    end else begin
      slot_next = slot_reg + 16'h1;
    end
  end
  // -------------------------------------------------------------
  // back-off engines and arbitration
  // -------------------------------------------------------------
  logic [NUM_CAT-1:0] zero;
  logic [NUM_CAT-1:0] win;
  logic [$clog2(NUM_CAT)-1:0] rr_reg, rr_next;
  genvar g;
  generate
    for (g = 0; g < NUM_CAT; g++) begin : g_bo
      logic [BO_W-1:0] bo_reg, bo_next;
      logic armed_reg, armed_next;
      always_comb begin
        bo_next = bo_reg;
        armed_next = armed_reg;
        if (seqCmd.boLoad[g]) begin
          bo_next = seqCmd.boValue;
          armed_next = 1'b1;
        end else if (win[g]) begin
          armed_next = 1'b0;
        end else if (slotEnd && slotIdle_reg && bo_reg != '0) begin
          bo_next = bo_reg - BO_W'(1);
        end
      end
      always_ff @(posedge mclk) begin
        if (reset) begin
          bo_reg <= '0;
          armed_reg <= 1'b0;
        end else begin
          bo_reg <= bo_next;
          armed_reg <= armed_next;
        end
      end
      assign zero[g] = armed_reg && bo_reg == '0 && queueReady[g];
    end
  endgenerate
  // policy choose among simultaneous zeros, fires on spacing trigger
  always_comb begin
    win = '0;
    rr_next = rr_reg;
    if (sifsTrig || slotEnd) begin
      for (int i = 0; i < NUM_CAT; i++) begin
        case (arbPolicy)
          WCT_POL_HIGH: begin
            if (zero[NUM_CAT-1-i] && win == '0) begin
              win[NUM_CAT-1-i] = 1'b1;
            end
          end
          WCT_POL_RR: begin
            if (zero[(int'(rr_reg) + i) % NUM_CAT] && win == '0) begin
              win[(int'(rr_reg) + i) % NUM_CAT] = 1'b1;
              rr_next = $clog2(NUM_CAT)'((int'(rr_reg) + i + 1)
                % NUM_CAT);
            end
          end
          default: begin
            if (zero[i] && win == '0) begin
              win[i] = 1'b1;
            end
          end
        endcase
      end
    end
    txStart = win;
  end
  // -------------------------------------------------------------
  // nav, tsf, tbtt
  // -------------------------------------------------------------
  logic [NAV_W-1:0] nav_reg, nav_next;
  logic [4:0] usCnt_reg, usCnt_next;
  logic [TSF_W-1:0] tsf_reg, tsf_next;
  logic usTick;
  assign usTick = usCnt_reg == 5'(US_CYC - 1);
  assign navBusy = nav_reg != '0;
  always_comb begin
    usCnt_next = usTick ? 5'h0 : usCnt_reg + 5'h1;
    nav_next = nav_reg;
    if (seqCmd.navLoad && seqCmd.navValue > nav_reg) begin
      nav_next = seqCmd.navValue;
    end else if (usTick && navBusy) begin
      nav_next = nav_reg - NAV_W'(1);
    end
    tsf_next = usTick ? tsf_reg + TSF_W'(1) : tsf_reg;
    if (seqCmd.tsfLoad) begin
      tsf_next = seqCmd.tsfValue;
    end
    tsfNow = tsf_reg;
    tbttTrig = usTick && tsf_reg == tbttTarget;
    offsetTrig = usTick && tsf_reg == offsetTarget;
  end
  // -------------------------------------------------------------
  // sleep control and phy control arbitration
  // -------------------------------------------------------------
  wct_pwr_t pwr_reg, pwr_next;
  logic [SLP_W-1:0] slp_reg, slp_next;
  logic [1:0] phyG_reg, phyG_next;
  // the timer counts slow ticks; mac logic is gated off meanwhile
  always_comb begin
    pwr_next = pwr_reg;
    slp_next = slp_reg;
    case (pwr_reg)
      WCT_AWAKE: begin
        if (seqCmd.sleepStart) begin
          slp_next = seqCmd.sleepCount;
          pwr_next = WCT_SLEEP;
        end
      end
      WCT_SLEEP: begin
        if (slowTick) begin
          if (slp_reg <= SLP_W'(1)) begin
            pwr_next = WCT_WAKE;
          end
          slp_next = slp_reg - SLP_W'(1);
        end
      end
      default: pwr_next = WCT_AWAKE;
    endcase
    macClkEn = pwr_reg == WCT_AWAKE || pwr_reg == WCT_WAKE;
    wakeEvent = pwr_reg == WCT_WAKE;
    // host wins a tie; owner holds until released
    phyG_next = phyG_reg;
    if (phyG_reg == 2'h0) begin
      if (hostPhyReq) phyG_next = 2'h1;
      else if (seqPhyReq) phyG_next = 2'h2;
    end else if (phyG_reg == 2'h1 && !hostPhyReq) begin
      phyG_next = 2'h0;
    end else if (phyG_reg == 2'h2 && !seqPhyReq) begin
      phyG_next = 2'h0;
    end
    phyCtlGrant = phyG_reg;
  end
  // state registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      fn_reg <= COEX_FN_RST;
      freqFn_reg <= FREQ_FN_RST;
      en_reg <= COEX_EN_RST;
      grant_reg <= 1'b0;
      ifs_reg <= 16'h0;
      slot_reg <= 16'h0;
      busyPrev_reg <= 1'b0;
      slotIdle_reg <= 1'b1;
      rr_reg <= '0;
      nav_reg <= '0;
      usCnt_reg <= 5'h0;
      tsf_reg <= '0;
      pwr_reg <= WCT_AWAKE;
      slp_reg <= '0;
      phyG_reg <= 2'h0;
    end else begin
      fn_reg <= fn_next;
      freqFn_reg <= freqFn_next;
      en_reg <= en_next;
      grant_reg <= grant_next;
      ifs_reg <= ifs_next;
      slot_reg <= slot_next;
      busyPrev_reg <= medBusy;
      slotIdle_reg <= slotIdle_next;
      rr_reg <= rr_next;
      nav_reg <= nav_next;
      usCnt_reg <= usCnt_next;
      tsf_reg <= tsf_next;
      pwr_reg <= pwr_next;
      slp_reg <= slp_next;
      phyG_reg <= phyG_next;
    end
  end
  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  property p_grant_off;
    @(posedge mclk) disable iff (reset) !en_reg[2] |=> !grant_reg;
  endproperty
  a_grant_off: assert property (p_grant_off) else $error("grant");
  property p_nav_busy;
    @(posedge mclk) disable iff (reset)
      navBusy |-> !sifsTrig && !rifsTrig && txStart == '0;
  endproperty
  a_nav_busy: assert property (p_nav_busy) else $error("nav");
  property p_sifs;
    @(posedge mclk) disable iff (reset)
      $fell(medBusy) |-> ##SIFS_CYC (sifsTrig || medBusy);
  endproperty
  a_sifs: assert property (p_sifs) else $error("sifs");
  property p_onehot;
    @(posedge mclk) disable iff (reset) $onehot0(txStart);
  endproperty
  a_onehot: assert property (p_onehot) else $error("win");
  property p_start_zero;
    @(posedge mclk) disable iff (reset) (txStart != '0) |-> zero != '0;
  endproperty
  a_start_zero: assert property (p_start_zero) else $error("bo");
  property p_sleep;
    @(posedge mclk) disable iff (reset)
      pwr_reg == WCT_SLEEP |-> !macClkEn;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep");
  property p_wake;
    @(posedge mclk) disable iff (reset)
      wakeEvent |=> macClkEn && pwr_reg == WCT_AWAKE;
  endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_tsf;
    @(posedge mclk) disable iff (reset)
      seqCmd.tsfLoad |=> tsfNow == $past(seqCmd.tsfValue);
  endproperty
  a_tsf: assert property (p_tsf) else $error("tsf");
endmodule : wct_channel_access
`default_nettype wire

// >>> wct_peer_radio.sv
// model of the collocated external radio on the coexistence pins
// assumes the bench resolves pad levels and hands back the grant pad
`timescale 1ns/1ps
`default_nettype none
module wct_peer_radio (
  input wire logic mclk,
  input wire logic wantAir,
  input wire logic highPrio,
  input wire logic grantPad,
  output logic prioDir,
  output logic rfActive,
  output logic restricted,
  output logic txOn
);
  // ---------------------------------------------------------------
  // peer activity
  // ---------------------------------------------------------------
  initial begin
    prioDir = 1'b0;
    rfActive = 1'b0;
    restricted = 1'b0;
    txOn = 1'b0;
  end
  // restricted flag leads activity by a cycle so the mac has notice
  always @(posedge mclk) begin
    restricted <= wantAir;
    rfActive <= wantAir & restricted;
    prioDir <= highPrio;
    txOn <= wantAir & restricted & grantPad; // air only when granted
  end
endmodule // wct_peer_radio
`default_nettype wire

// >>> wct_pkg.sv
// package for the channel-access and timing block: constants and carriers
// assumes a 25 MHz mclk and a 1 us slot-time base derived from it
package wct_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int US_NS = 1000;
  localparam int CLK_NS = 40;
  localparam int US_CYC = US_NS / CLK_NS; // cycles per microsecond
  localparam int RIFS_US = 2;
  localparam int SIFS_US = 10;
  localparam int SLOT_US = 9;
  localparam int NUM_AC = 4;
  localparam int TSF_W = 64;
  localparam int NAV_W = 16;
  localparam int BO_W = 10;
  localparam int SLP_W = 32;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] COEX_FN_RST = 3'h7; // three pins in coex role
  localparam logic FREQ_FN_RST = 1'h0;       // fourth pin is gpio
  localparam logic [3:0] COEX_EN_RST = 4'h0;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    WCT_POL_LOW, WCT_POL_HIGH, WCT_POL_RR
  } wct_pol_t;
  typedef enum logic [1:0] {
    WCT_AWAKE, WCT_SLEEP, WCT_WAKE
  } wct_pwr_t;
  // coexistence pin set: input, output and output enable per pin
  typedef struct packed {
    logic [3:0] pinIn;
    logic [3:0] pinOut;
    logic [3:0] pinOe;
  } wct_pins_t;
  // sequencer command carrier
  typedef struct packed {
    logic tsfLoad;
    logic [TSF_W-1:0] tsfValue;
    logic navLoad;
    logic [NAV_W-1:0] navValue;
    logic [NUM_AC-1:0] boLoad;
    logic [BO_W-1:0] boValue;
    logic sleepStart;
    logic [SLP_W-1:0] sleepCount;
  } wct_cmd_t;
endpackage : wct_pkg
